// *** inc/lce_pkg.sv ***
package lce_pkg;

    // instruction operation codes
    typedef enum logic [3:0] {
        OP_NOP        = 4'b0000,
        OP_LOAD       = 4'b0001,
        OP_LOAD_INV   = 4'b0010,
        OP_CONJ       = 4'b0011,
        OP_CONJ_INV   = 4'b0100,
        OP_DISJ       = 4'b0101,
        OP_DISJ_INV   = 4'b0110,
        OP_MERGE_SER  = 4'b0111,
        OP_MERGE_PAR  = 4'b1000,
        OP_RISE_PULSE = 4'b1001,
        OP_FALL_PULSE = 4'b1010,
        OP_TEST_ON    = 4'b1011,
        OP_TEST_OFF   = 4'b1100,
        OP_INVERT     = 4'b1101,
        OP_TERMINATE  = 4'b1110
    } lce_op_t;

    // one-word encoding covers core i/o bits up to word 511 bit 15
    localparam logic [15:0] CORE_IO_LAST_WORD = 16'h01ff;
    localparam logic [3:0]  BCD_DIGIT_MAX     = 4'h9;
    localparam logic [7:0]  BIT_INDEX_MAX     = 8'h15;
    localparam logic [3:0]  BCD_TENS_MAX      = 4'h1;
    localparam int          STACK_DEPTH       = 16;
    localparam int          EDGE_SLOTS        = 256;

    // one instruction step as presented by program memory
    typedef struct packed {
        lce_op_t     op;
        logic        shortForm;   // one-word encoding
        logic [15:0] wordAddr;    // operand word address
        logic [3:0]  bitIdx;      // operand bit position (bit instructions)
        logic [15:0] bitIndexBcd; // bit-test index operand, BCD
        logic        indirect;    // operand taken through an indirect word
        logic [15:0] indirectRaw; // raw indirect word content
        logic [7:0]  edgeSlot;    // instance number of an edge instruction
    } lce_instr_t;

    // result of one step
    typedef struct packed {
        logic cond;
        logic fault;
        logic scanDone;
        logic encodingErr;
    } lce_result_t;

endpackage

// *** logic/lce_edge_store.sv ***
`timescale 1ns/100ps
module lce_edge_store #(
    parameter int SLOTS = lce_pkg::EDGE_SLOTS,
    parameter int AW    = 8
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    // access port
    input  wire logic [AW-1:0] slot,
    input  wire logic          wrEn,
    input  wire logic          wrVal,
    output logic               prevCond
);

    logic [SLOTS-1:0] mem_q;
    logic [SLOTS-1:0] mem_d;

    // update the slot of the instance that executes
    always_comb begin
        mem_d = mem_q;
        if (wrEn) begin
            mem_d[slot] = wrVal;
        end
    end

    // all previous conditions start OFF
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_q <= '0;
        end else begin
            mem_q <= mem_d;
        end
    end

    assign prevCond = mem_q[slot];

endmodule

// *** logic/lce_evaluator.sv ***
`timescale 1ns/100ps
// Summary of operation
// - load sets condition from bit, maybe inverted
// - conjoin ANDs condition with bit or inverse
// - disjoin ORs condition with bit or inverse
// - merges combine condition with stacked block
// - rising pulse ON one scan on rise
// - falling pulse ON one scan on fall
// - test on gives selected word bit
// - test off gives inverted word bit
// - bit index is BCD zero to fifteen
// - bad BCD index or indirect raises fault
// - invert flips preceding condition, mid-line only; not checked, it flips the condition at any position
// - one-word form only for core area
// - any bit used any number times
// - edge compares with own last scan
module lce_evaluator #(
    parameter int STACK_DEPTH = lce_pkg::STACK_DEPTH,
    parameter int EDGE_SLOTS  = lce_pkg::EDGE_SLOTS
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // scan control
    input  wire logic               scanStart,
    // instruction stream
    input  wire logic               instrValid,
    input  wire lce_pkg::lce_instr_t instr,
    // data memory read data for the current step
    input  wire logic [15:0]        dataWord,
    // results
    output lce_pkg::lce_result_t    result,
    output logic                    resultValid,
    output logic                    fault_flag,
    output logic                    stackOverflow
);

    // stack pointer counts from empty up to full, both ends included
    localparam int SP_W = $clog2(STACK_DEPTH + 1);

    // true when every nibble is a decimal digit
    function automatic logic isBcd(input logic [15:0] v);
        isBcd = (v[3:0] <= lce_pkg::BCD_DIGIT_MAX) && (v[7:4] <= lce_pkg::BCD_DIGIT_MAX)
             && (v[11:8] <= lce_pkg::BCD_DIGIT_MAX)
             && (v[15:12] <= lce_pkg::BCD_DIGIT_MAX);
    endfunction

    // two-digit BCD to binary bit position
    function automatic logic [3:0] bcdToBit(input logic [15:0] v);
        logic [4:0] tens;
        // tens digit is 0 or 1, so ten is eight plus two
        tens = {1'b0, v[4], 3'b000} + {3'b000, v[4], 1'b0};
        bcdToBit = 4'(tens + {1'b0, v[3:0]});
    endfunction

    // decoded step and edge store access
    lce_pkg::lce_op_t op;
    logic               stepTaken;
    logic               shortFormBad;
    logic               opBit;
    logic [3:0]         testPos;
    logic               indexOk;
    logic               prevCond;
    logic               edgeWr;

    // execution condition, per-scan flags and block stack
    logic                    cond_q,  cond_d;
    logic                    fault_q, fault_d;
    logic                    encErr_q, encErr_d;
    logic                    done_q,  done_d;
    logic                    valid_q, valid_d;
    logic                    ovf_q,   ovf_d;
    logic [STACK_DEPTH-1:0]  stack_q, stack_d;
    logic [SP_W-1:0]         sp_q,    sp_d;

    // operand bit of the basic instructions; any address, any number of times
    assign op      = instr.op;
    assign opBit   = dataWord[instr.bitIdx];
    assign testPos = bcdToBit(instr.bitIndexBcd);

    // a step runs only outside scan start and before the terminator
    assign stepTaken = instrValid && !scanStart && !done_q;

    // one-word form is kept for the six basic instructions in the core area
    assign shortFormBad = instr.shortForm
                       && (op < lce_pkg::OP_LOAD || op > lce_pkg::OP_DISJ_INV
                           || instr.wordAddr > lce_pkg::CORE_IO_LAST_WORD);

    // bit-test index must be 0000 to 0015 in BCD
    assign indexOk = isBcd(instr.bitIndexBcd) && (instr.bitIndexBcd[15:8] == 8'h00)
                  && (instr.bitIndexBcd[7:4] <= lce_pkg::BCD_TENS_MAX)
                  && (instr.bitIndexBcd[7:0] <= lce_pkg::BIT_INDEX_MAX);

    // the edge store must not move on a step that scan start overrides
    assign edgeWr  = stepTaken
                  && (op == lce_pkg::OP_RISE_PULSE || op == lce_pkg::OP_FALL_PULSE);

    // previous condition per edge instruction instance
    lce_edge_store #(
        .SLOTS (EDGE_SLOTS),
        // slot width follows the instance number field
        .AW    ($bits(instr.edgeSlot))
    ) u_edge (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .slot     (instr.edgeSlot),
        .wrEn     (edgeWr),
        .wrVal    (cond_q),
        .prevCond (prevCond)
    );

    // condition evaluation, block stack and flags
    always_comb begin
        cond_d   = cond_q;
        fault_d  = fault_q;
        encErr_d = 1'b0;
        done_d   = done_q;
        valid_d  = 1'b0;
        ovf_d    = ovf_q;
        stack_d  = stack_q;
        sp_d     = sp_q;
        if (scanStart) begin
            cond_d  = 1'b0;
            fault_d = 1'b0;
            done_d  = 1'b0;
            ovf_d   = 1'b0;
            sp_d    = '0;
            // clear the entries too, or an empty pop would see last scan's blocks
            stack_d = '0;
        end else if (stepTaken) begin
            valid_d = 1'b1;
            // misuse is flagged for one cycle, the step still executes
            if (shortFormBad) begin
                encErr_d = 1'b1;
            end
            case (op)
                lce_pkg::OP_LOAD, lce_pkg::OP_LOAD_INV: begin
                    // push the unused block condition
                    if (sp_q < SP_W'(STACK_DEPTH)) begin
                        stack_d = {stack_q[STACK_DEPTH-2:0], cond_q};
                        sp_d    = sp_q + 1'b1;
                    end else begin
                        // full: the push is dropped, flag sticks for the scan
                        ovf_d = 1'b1;
                    end
                    cond_d = (op == lce_pkg::OP_LOAD) ? opBit : !opBit;
                end
                // basic instructions fold the operand bit into the condition
                lce_pkg::OP_CONJ:     cond_d = cond_q & opBit;
                lce_pkg::OP_CONJ_INV: cond_d = cond_q & !opBit;
                lce_pkg::OP_DISJ:     cond_d = cond_q | opBit;
                lce_pkg::OP_DISJ_INV: cond_d = cond_q | !opBit;
                lce_pkg::OP_MERGE_SER, lce_pkg::OP_MERGE_PAR: begin
                    // pop the most recent unused block
                    if (op == lce_pkg::OP_MERGE_SER) begin
                        cond_d = cond_q & stack_q[0];
                    end else begin
                        cond_d = cond_q | stack_q[0];
                    end
                    // popping an empty stack yields OFF
                    stack_d = {1'b0, stack_q[STACK_DEPTH-1:1]};
                    if (sp_q != '0) begin
                        sp_d = sp_q - 1'b1;
                    end
                end
                // the store keeps the incoming condition, not the pulse
                lce_pkg::OP_RISE_PULSE: cond_d = cond_q & !prevCond;
                lce_pkg::OP_FALL_PULSE: cond_d = !cond_q & prevCond;
                lce_pkg::OP_TEST_ON, lce_pkg::OP_TEST_OFF: begin
                    if (!indexOk || (instr.indirect && !isBcd(instr.indirectRaw))) begin
                        fault_d = 1'b1;
                    end
                    // a bad index still selects a bit, the flag marks it
                    if (op == lce_pkg::OP_TEST_ON) begin
                        cond_d = dataWord[testPos];
                    end else begin
                        cond_d = !dataWord[testPos];
                    end
                end
                lce_pkg::OP_INVERT:    cond_d = !cond_q;
                // later steps are refused until the next scan start
                lce_pkg::OP_TERMINATE: done_d = 1'b1;
                default: ;
            endcase
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cond_q   <= 1'b0;
            fault_q  <= 1'b0;
            encErr_q <= 1'b0;
            done_q   <= 1'b0;
            valid_q  <= 1'b0;
            ovf_q    <= 1'b0;
            stack_q  <= '0;
            sp_q     <= '0;
        end else begin
            cond_q   <= cond_d;
            fault_q  <= fault_d;
            encErr_q <= encErr_d;
            done_q   <= done_d;
            valid_q  <= valid_d;
            ovf_q    <= ovf_d;
            stack_q  <= stack_d;
            sp_q     <= sp_d;
        end
    end

    // registered outputs
    assign result.cond        = cond_q;
    assign result.fault       = fault_q;
    assign result.scanDone    = done_q;
    assign result.encodingErr = encErr_q;
    assign resultValid        = valid_q;
    // fault appears both in the result and on its own pin
    assign fault_flag         = fault_q;
    assign stackOverflow      = ovf_q;

endmodule

// *** verification/lce_data_mem_model.sv ***
`timescale 1ns/100ps
// sixteen-word data image, filled by the bench, read with no wait
module lce_data_mem_model (
    // fill port
    input  wire logic        sys_clk,
    input  wire logic        wrEn,
    input  wire logic [3:0]  wrAddr,
    input  wire logic [15:0] wrData,
    // read port
    input  wire logic [15:0] rdAddr,
    output logic [15:0]      dataWord
);
    logic [15:0] mem [16];
    // store a word when asked
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
    // any word may be read by any number of steps
    assign dataWord = mem[rdAddr[3:0]];
endmodule

// *** verification/lce_evaluator_monitor.sv ***
`timescale 1ns/100ps
module lce_evaluator_monitor #(
    parameter int EDGE_SLOTS = 256
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 sys_rst,
    // steps
    input wire logic                 scanStart,
    input wire logic                 instrValid,
    input wire lce_pkg::lce_instr_t  instr,
    input wire logic [15:0]          dataWord,
    // results
    input wire lce_pkg::lce_result_t result,
    input wire logic                 resultValid,
    input wire logic                 fault_flag,
    input wire logic                 stackOverflow
);
    logic       tk, ok, tkQ, bQ, cQ, eQ, okQ;
    logic [3:0] ix, opQ;
    logic       prv [EDGE_SLOTS];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // step taken, test index legal and decoded
    assign tk = instrValid & ~scanStart & ~result.scanDone;
    assign ok = instr.bitIndexBcd <= 16'h0015 && instr.bitIndexBcd[3:0] <= 4'h9;
    assign ix = instr.bitIndexBcd[3:0] + (instr.bitIndexBcd[4] ? 4'ha : 4'h0);
    // remember the step and one previous condition per edge slot
    always_ff @(posedge sys_clk) begin
        tkQ <= tk & ~sys_rst;
        opQ <= instr.op;
        bQ  <= dataWord[instr.op inside {4'hb, 4'hc} ? ix : instr.bitIdx];
        cQ  <= result.cond;
        okQ <= ok & ~instr.indirect;
        eQ  <= prv[instr.edgeSlot];
        if (sys_rst) begin
            prv <= '{default: 1'b0};
        end else if (tk && instr.op inside {4'h9, 4'ha}) begin
            prv[instr.edgeSlot] <= result.cond;
        end
    end
    load_cond_a: assert property (
        tkQ && opQ inside {1, 2} |-> result.cond == (bQ ^ opQ[1])) else $error("bad load");
    conj_cond_a: assert property (
        tkQ && opQ inside {3, 4} |-> result.cond == (cQ & (bQ ^ opQ[2]))) else $error("bad and");
    disj_cond_a: assert property (
        tkQ && opQ inside {5, 6} |-> result.cond == (cQ | (bQ ^ opQ[1]))) else $error("bad or");
    edge_pulse_a: assert property (
        tkQ && opQ inside {9, 10} |-> result.cond == (opQ[0] ? cQ & ~eQ : ~cQ & eQ))
        else $error("bad pulse");
    bit_test_a: assert property (
        tkQ && okQ && opQ inside {11, 12} |-> result.cond == (bQ ^ opQ[2])) else $error("bad test");
    invert_cond_a: assert property (
        tkQ && opQ == 13 |-> result.cond == ~cQ) else $error("bad invert");
    bad_index_a: assert property (
        tk && instr.op inside {4'hb, 4'hc} && !ok |=> fault_flag) else $error("no fault");
    scan_clear_a: assert property (
        scanStart |=> !result.cond && !fault_flag && !stackOverflow) else $error("no clear");
endmodule
bind lce_evaluator lce_evaluator_monitor #(.EDGE_SLOTS(EDGE_SLOTS)) u_mon (.sys_clk, .sys_rst,
    .scanStart, .instrValid, .instr, .dataWord, .result, .resultValid, .fault_flag, .stackOverflow);

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
    logic                 sys_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 scanStart = 1'b0;
    logic                 instrValid = 1'b0;
    logic                 wrEn = 1'b0;
    logic                 c, resultValid, fault_flag, stackOverflow;
    lce_pkg::lce_instr_t  instr = '0;
    lce_pkg::lce_result_t result;
    logic [3:0]           wrAddr = '0, op;
    logic [15:0]          wrData = '0, raw = '0, dataWord, img [16];
    logic                 prv [256] = '{default: 1'b0};
    logic                 stk [$];
    logic [1:0]           exq [$];
    logic [31:0]          r;
    int                   err_total = 0, cmp_count = 0;
    lce_evaluator u_dut (.sys_clk, .sys_rst, .scanStart, .instrValid, .instr, .dataWord,
        .result, .resultValid, .fault_flag, .stackOverflow);
    lce_data_mem_model u_mem (.sys_clk, .wrEn, .wrAddr, .wrData, .rdAddr(instr.wordAddr),
        .dataWord);
    // clock and timeout
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
    task automatic chk(input logic [1:0] s, input logic [1:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %0t seen %b want %b", $time, s, e);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // drive one step and note the condition and encoding flag it must give
    task automatic step(input logic [3:0] o, input logic [15:0] a, input logic [3:0] b,
                        input logic [15:0] n, input logic [7:0] s, input logic f);
        logic v, e;
        v = img[a[3:0]][b];
        e = img[a[3:0]][4'(n[3:0] + (n[4] ? 4'ha : 4'h0))];
        case (o)
            4'h1, 4'h2: begin
                if (stk.size() < 16) stk.push_back(c);
                e = v ^ o[1];
            end
            4'h3, 4'h4: e = c & (v ^ o[2]);
            4'h5, 4'h6: e = c | (v ^ o[1]);
            4'h7, 4'h8: begin
                e = stk.size() > 0 ? stk.pop_back() : 1'b0;
                e = o[0] ? c & e : c | e;
            end
            4'h9, 4'ha: begin
                e = o[0] ? c & ~prv[s] : ~c & prv[s];
                prv[s] = c;
            end
            4'hb, 4'hc: e = e ^ o[2];
            4'hd: e = ~c;
            default: e = c;
        endcase
        c = e;
        @(negedge sys_clk);
        scanStart <= 1'b0;
        instrValid <= 1'b1;
        instr <= {o, f, a, b, n, |raw, raw, s};
        if (o != 4'he) exq.push_back({e, f & ~(o <= 4'h6 && a <= 16'h01ff)});
    endtask
    task automatic restart();
        @(negedge sys_clk);
        scanStart <= 1'b1;
        instrValid <= 1'b0;
        c = 1'b0;
        stk.delete();
    endtask
    // close the line and the scan, then offer a step that must be refused
    task automatic finish_scan();
        step(4'h3, '0, '0, '0, '0, 1'b0);
        step(4'he, '0, '0, '0, '0, 1'b0);
        @(negedge sys_clk) instr.op <= lce_pkg::OP_LOAD;
        @(negedge sys_clk) instrValid <= 1'b0;
        chk({result.scanDone, resultValid}, 2'b10);
    endtask
    // compare each executed step with the oldest note
    always @(posedge sys_clk) begin
        if (resultValid && !result.scanDone) begin
            chk({result.cond, result.encodingErr}, exq.pop_front());
        end
    end
    // reset, fill the image, random scans, faults, short form and a full stack
    initial begin
        r = $urandom(96);
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst <= 1'b0;
        chk({result.cond, fault_flag}, 2'b00);
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk) img[i] = 16'($urandom);
            wrEn <= 1'b1;
            wrAddr <= 4'(i);
            wrData <= img[i];
        end
        repeat (24) begin
            restart();
            repeat (12) begin
                r = $urandom;
                op = 4'(r % 13 + 1);
                step(op, {12'h0, r[15:12]}, r[19:16], {11'h0, r[11:8] > 9, r[11:8] % 4'ha},
                     {6'h0, r[21:20]}, r[22] & (op <= 4'h6));
            end
            finish_scan();
        end
        for (int k = 0; k < 3; k++) begin
            restart();
            raw = k == 1 ? 16'h00a0 : 16'h0000;
            step(4'hb, '0, '0, k == 0 ? 16'h0016 : 16'h0009, '0, 1'b0);
            @(negedge sys_clk) instrValid <= 1'b0;
            chk({fault_flag, result.fault}, {2{k < 2}});
        end
        raw = '0;
        restart();
        step(4'h1, 16'h0200, 4'h2, '0, '0, 1'b1);
        step(4'hc, 16'h01ff, 4'h0, 16'h0007, '0, 1'b1);
        for (int k = 0; k < 36; k++) begin
            step(k < 18 ? 4'h2 : 4'(7 + k % 2), 16'(k), '0, '0, '0, 1'b0);
        end
        @(negedge sys_clk) instrValid <= 1'b0;
        chk(2'(stackOverflow), 2'b01);
        finish_scan();
        repeat (3) @(negedge sys_clk);
        print_verdict();
    end
endmodule
